// *** bench/cascadable_down_counter_timers_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module cascadable_down_counter_timers_bench
   import cdt_pkg::*;
;
   localparam logic [7:0] RTAB [7] = '{OFS_PRE_A, OFS_PRE_B, OFS_PRE_C, OFS_CTRL, OFS_MODE_C, OFS_STAT, OFS_EN};
   logic        mclk, rst, psel, penable, pwrite, port3_bit1, port3_bit2;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic        pready, pslverr, port3_bit5, timer_a_irq, timer_b_irq, ext_irq_zero, uart_bit_clk, irq, rd_e;
   int          num_errors, compares, t1, t2, hits, lastk, n, cn, dv;
   int          exp_q [$];  // model of what each rw_readback must return

   cdt_top cdt_top_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port3_bit1(port3_bit1), .port3_bit2(port3_bit2), .port3_bit5(port3_bit5), .timer_a_irq(timer_a_irq),
      .timer_b_irq(timer_b_irq), .ext_irq_zero(ext_irq_zero), .uart_bit_clk(uart_bit_clk), .irq(irq));

   // 4 ns clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // ----------------------------------------------
   // shared tasks
   // ----------------------------------------------
   task give_verdict;
      $display("comparisons %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 40);
      if (k >= 40) chk("pready", 1, 0);
      rd_v = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask : settle

   // waits for an end pulse of timer_a (0), timer_b (1) or the shared line (2); -1 if none
   task wait_ev(input int w, input int lim, output int t);
      t = -1;
      for (int i = 0; i < lim && t < 0; i++) begin
         @(posedge mclk);
         #1;
         if ((w == 0 ? timer_a_irq : w == 1 ? timer_b_irq : ext_irq_zero) === 1'b1) t = int'($time) / 4;
      end
   endtask : wait_ev

   // model: one internal tick per 2 mclk, so a period is 2 * count * divider
   task per(input int w, input int c, input int d, input string nm);
      wait_ev(w, 4 * c * d + 100, t1);
      wait_ev(w, 2 * c * d + 50, t2);
      chk(nm, 2 * c * d, t2 - t1);
   endtask : per

   // ----------------------------------------------
   // main sequence
   // ----------------------------------------------
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, port3_bit1, port3_bit2} = '0;
      paddr = '0;
      pwdata = '0;
      num_errors = 0;
      compares = 0;
      n = $urandom(84);
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      foreach (RTAB[i]) begin
         apb(1'b0, RTAB[i], 0);
         chk("reset_value", 0, rd_v);
      end
      chk("pin_reset", 0, port3_bit5);
      apb(1'b1, 8'h30, 32'hFF);
      apb(1'b0, 8'h30, 0);
      chk("unmapped_err", 1, rd_e);
      chk("unmapped_data", 0, rd_v);
      for (int i = 0; i < 2; i++) begin
         n = $urandom & (i ? 32'h7 : 32'hFF);
         exp_q.push_back(n);
         apb(1'b1, i ? OFS_EN : OFS_PRE_B, n);
         apb(1'b0, i ? OFS_EN : OFS_PRE_B, 0);
         chk("rw_readback", exp_q.pop_front(), rd_v);
         apb(1'b1, i ? OFS_EN : OFS_PRE_B, 0);
      end
      // timer_a alone: its high byte must not count in 8-bit length
      apb(1'b1, BANK_HI | OFS_A_LO, 5);
      for (int i = 0; i < 4; i++) begin
         cn = i == 0 ? 1 : i == 1 ? 2 + $urandom % 8 : i == 2 ? 2 : 256;
         dv = i == 0 ? 1 : i == 1 ? 1 + $urandom % 5 : i == 2 ? 64 : 1;
         apb(1'b1, OFS_A_LO, cn[7:0]);
         apb(1'b1, OFS_PRE_A, {dv[5:0], 2'b01});
         apb(1'b1, OFS_CTRL, 3);
         per(0, cn, dv, "a_period");
         apb(1'b1, OFS_CTRL, 0);
      end
      apb(1'b1, OFS_PRE_C, CASC_A16);
      apb(1'b1, BANK_HI | OFS_A_LO, 1);
      apb(1'b1, OFS_A_LO, 2);
      apb(1'b1, OFS_PRE_A, 5);
      apb(1'b1, OFS_CTRL, 3);
      per(0, 258, 1, "a16_period");
      apb(1'b1, OFS_CTRL, 0);
      apb(1'b1, OFS_PRE_C, CASC_B24);
      apb(1'b1, BANK_HI | OFS_A_LO, 0);
      apb(1'b1, BANK_HI | OFS_B_LO, 1);
      apb(1'b1, OFS_B_LO, 1);
      apb(1'b1, OFS_PRE_B, 5);
      apb(1'b1, OFS_CTRL, 12);
      per(1, 257, 1, "b24_period");
      apb(1'b1, OFS_CTRL, 0);
      // timer_c 16-bit modulo, switched to single pass in mid-count
      apb(1'b1, OFS_PRE_C, 8'h06);
      apb(1'b1, BANK_HI | OFS_C_LO, 1);
      apb(1'b1, OFS_C_LO, 1);
      apb(1'b1, OFS_MODE_C, 8'h0F);
      per(2, 257, 1, "c16_period");
      chk("pin_two_ends", 0, port3_bit5);
      apb(1'b1, OFS_MODE_C, 8'h0A);
      wait_ev(2, 600, t1);
      chk("c_last_period", 514, t1 - t2);
      chk("pin_third_end", 1, port3_bit5);
      wait_ev(2, 1200, t1);
      chk("c_stopped", -1, t1);
      apb(1'b0, OFS_MODE_C, 0);
      chk("c_mode", 8'h88, rd_v);
      apb(1'b1, OFS_MODE_C, 8'h08);
      apb(1'b0, OFS_MODE_C, 0);
      chk("c_flag_cleared", 8'h08, rd_v);
      apb(1'b0, OFS_STAT, 0);
      chk("status_all", 7, rd_v);
      apb(1'b1, OFS_MODE_C, 0);
      settle();
      chk("pin_disabled", 0, port3_bit5);
      // interrupt status, mask and clear with a single-pass timer_a
      apb(1'b1, OFS_CLR, 7);
      apb(1'b0, OFS_STAT, 0);
      chk("status_cleared", 0, rd_v);
      apb(1'b1, OFS_PRE_C, CASC_C32);
      apb(1'b1, OFS_A_LO, 2);
      apb(1'b1, OFS_PRE_A, 4);
      apb(1'b1, OFS_CTRL, 3);
      wait_ev(0, 100, t1);
      wait_ev(0, 100, t2);
      chk("a_single_pass", -1, t2);
      apb(1'b0, OFS_CTRL, 0);
      chk("ctrl_stopped", 0, rd_v);
      apb(1'b0, OFS_STAT, 0);
      chk("status_a", 1, rd_v);
      apb(1'b1, OFS_EN, 6);
      settle();
      chk("irq_masked", 0, irq);
      apb(1'b1, OFS_EN, 1);
      settle();
      chk("irq_enabled", 1, irq);
      apb(1'b1, OFS_CLR, 1);
      settle();
      chk("irq_cleared", 0, irq);
      // external request pin onto the shared line
      @(posedge mclk);
      port3_bit2 <= 1'b1;
      settle();
      settle();
      chk("ext_pin_high", 1, ext_irq_zero);
      // shared line follows the request pin level back to low
      @(posedge mclk);
      port3_bit2 <= 1'b0;
      settle();
      settle();
      chk("ext_pin_low", 0, ext_irq_zero);
      // timer_b from the external clock pin, one edge every 12 mclk
      apb(1'b1, OFS_B_LO, 3);
      apb(1'b1, OFS_PRE_B, 7);
      apb(1'b1, OFS_CTRL, 12);
      hits = 0;
      lastk = 0;
      for (int k = 0; k < 12; k++) begin
         for (int j = 0; j < 12; j++) begin
            @(posedge mclk);
            port3_bit1 <= (j < 6);
            #1;
            if (timer_b_irq === 1'b1) begin
               if (hits > 0) chk("b_ext_edges", 3, k - lastk);
               hits++;
               lastk = k;
            end
         end
      end
      chk("b_ext_seen", 1, hits >= 3);
      give_verdict();
   end

   // watchdog: about four times the expected run of some 7000 cycles
   initial begin
      #120000;
      chk("watchdog", 0, 1);
      give_verdict();
   end
endmodule : cascadable_down_counter_timers_bench
`default_nettype wire

// *** bench/cdt_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdt_checker
   import cdt_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        port3_bit1,
   input wire logic        port3_bit2,
   input wire logic        port3_bit5,
   input wire logic        timer_a_irq,
   input wire logic        timer_b_irq,
   input wire logic        ext_irq_zero,
   input wire logic        uart_bit_clk,
   input wire logic        irq
);
   // ----------------------------------------------
   // bus and event checks
   // ----------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
   err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("pslverr stray");
   a_pulse_a: assert property (timer_a_irq |=> !timer_a_irq) else $error("timer_a_irq held");
   b_pulse_a: assert property ($rose(timer_b_irq) |=> !timer_b_irq) else $error("timer_b_irq held");
   uart_follow_a: assert property (timer_a_irq == (uart_bit_clk ^ $past(uart_bit_clk)))
      else $error("uart clock not tied to timer_a end");
   pin_rise_a: assert property ($rose(port3_bit5) |-> ext_irq_zero) else $error("pin rose alone");
   ext_pin_a: assert property (port3_bit2 [*3] |-> ##[1:3] ext_irq_zero) else $error("pin irq lost");
   ext_quiet_a: assert property ((!port3_bit2) [*4] ##0 $stable(port3_bit5) |-> !ext_irq_zero)
      else $error("ext irq without cause");
   // outputs quiet while in reset, whatever came before
   reset_quiet_a: assert property (disable iff (1'b0) rst |=> !pready && !port3_bit5 && !irq
      && !timer_a_irq && !timer_b_irq && !ext_irq_zero && prdata == 32'h0) else $error("reset leak");
   cover property (timer_a_irq);
   cover property (timer_b_irq);
   cover property ($rose(port3_bit5));
   cover property (pslverr);
   cover property (irq);
endmodule : cdt_checker
bind cdt_top cdt_checker cdt_checker_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .port3_bit1(port3_bit1), .port3_bit2(port3_bit2), .port3_bit5(port3_bit5), .timer_a_irq(timer_a_irq),
   .timer_b_irq(timer_b_irq), .ext_irq_zero(ext_irq_zero), .uart_bit_clk(uart_bit_clk), .irq(irq));
`default_nettype wire

// *** core/cdt_pkg.sv ***
`default_nettype none
package cdt_pkg;
   // ----------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------
   localparam logic [7:0] OFS_A_LO   = 8'h00;
   localparam logic [7:0] OFS_B_LO   = 8'h04;
   localparam logic [7:0] OFS_C_LO   = 8'h08;
   localparam logic [7:0] OFS_PRE_A  = 8'h0C;
   localparam logic [7:0] OFS_PRE_B  = 8'h10;
   localparam logic [7:0] OFS_PRE_C  = 8'h14;
   localparam logic [7:0] OFS_CTRL   = 8'h18;
   localparam logic [7:0] OFS_MODE_C = 8'h1C;
   localparam logic [7:0] OFS_STAT   = 8'h20;
   localparam logic [7:0] OFS_CLR    = 8'h24;
   localparam logic [7:0] OFS_EN     = 8'h28;
   localparam logic [7:0] BANK_HI    = 8'h40;
   // ----------------------------------------------
   // field positions
   // ----------------------------------------------
   localparam int PRE_MOD   = 0;
   localparam int PRE_EXT   = 1;
   localparam int PRE_DIV_L = 2;
   localparam int CT_A_LD   = 0;
   localparam int CT_A_EN   = 1;
   localparam int CT_B_LD   = 2;
   localparam int CT_B_EN   = 3;
   localparam int MD_LD     = 0;
   localparam int MD_EN     = 1;
   localparam int MD_RELOAD = 2;
   localparam int MD_OUTEN  = 3;
   localparam int MD_EOC    = 7;
   // ----------------------------------------------
   // cascade codes and reset values
   // ----------------------------------------------
   localparam logic [1:0] CASC_C32 = 2'h0;  // a8  b8  c32
   localparam logic [1:0] CASC_C24 = 2'h1;  // a8  b16 c24
   localparam logic [1:0] CASC_A16 = 2'h2;  // a16 b16 c16
   localparam logic [1:0] CASC_B24 = 2'h3;  // a8  b24 c16
   localparam logic [7:0] PRE_RST  = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [2:0] IRQ_RST  = 3'h0;
endpackage : cdt_pkg
`default_nettype wire

// *** core/cdt_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
// divides a stream of source ticks by 1..64 (code 0 means 64)
module cdt_prescaler
   import cdt_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       restart,
   input  wire logic       src_tick,
   input  wire logic [5:0] div,
   output logic            tick
);
   logic [5:0] cnt_r;

   // -----------------------------------------------
   // divider
   // -----------------------------------------------
   // divide by div
   always_ff @(posedge mclk) begin
      if (rst || restart) begin
         cnt_r <= 6'h00;
         tick  <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (src_tick) begin
            if (cnt_r == div - 6'h01) begin   // 0 - 1 wraps to 63: divide by 64
               cnt_r <= 6'h00;
               tick  <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 6'h01;
            end
         end
      end
   end
endmodule : cdt_prescaler
`default_nettype wire

// *** core/cdt_top.sv ***
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cdt_top
   import cdt_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        port3_bit1,
   input  wire logic        port3_bit2,
   output logic             port3_bit5,
   output logic             timer_a_irq,
   output logic             timer_b_irq,
   output logic             ext_irq_zero,
   output logic             uart_bit_clk,
   output logic             irq
);
   // -----------------------------------------------
   // state
   // -----------------------------------------------
   logic [7:0]  a_lo_r, a_hi_r, b_lo_r, b_hi_r, c_lo_r, c_hi_r;
   logic [7:0]  ra_lo_r, ra_hi_r, rb_lo_r, rb_hi_r, rc_lo_r, rc_hi_r;
   logic [7:0]  pre_a_r, pre_b_r, pre_c_r;
   logic        run_a_r, run_b_r, run_c_r;
   logic        reload_c_r, outen_c_r, eoc_c_r;
   logic [2:0]  stat_r, en_r;
   logic        half_r;
   logic [2:0]  ext_sync_r;
   logic [1:0]  p32_sync_r;
   logic        wr, rd_setup;
   logic        ld_a, ld_b, ld_c, en_a_w, en_b_w, en_c_w;
   logic        tick_a, tick_b, tick_c, src_b;
   logic [31:0] cur_a, cur_b, cur_c, rel_a, rel_b, rel_c;
   logic [31:0] msk_a, msk_b, msk_c, nxt_a, nxt_b, nxt_c;
   logic        term_a, term_b, term_c;
   logic [1:0]  casc;
   logic [31:0] rdata;
   logic        hit;

   assign casc = pre_c_r[1:0];

   // -----------------------------------------------
   // apb slave: one wait state, answer from flops
   // -----------------------------------------------
   assign rd_setup = psel & penable & ~pready;
   assign wr       = psel & penable & pready & pwrite;

   always_ff @(posedge mclk) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= rd_setup;
         pslverr <= rd_setup & ~hit;
         prdata  <= (rd_setup & ~pwrite) ? rdata : 32'h0000_0000;
      end
   end

   always_comb begin
      hit   = 1'b1;
      rdata = 32'h0000_0000;
      case (paddr)
         OFS_A_LO:           rdata[7:0] = a_lo_r;
         OFS_B_LO:           rdata[7:0] = b_lo_r;
         OFS_C_LO:           rdata[7:0] = c_lo_r;
         OFS_A_LO | BANK_HI: rdata[7:0] = a_hi_r;
         OFS_B_LO | BANK_HI: rdata[7:0] = b_hi_r;
         OFS_C_LO | BANK_HI: rdata[7:0] = c_hi_r;
         OFS_PRE_A:          rdata[7:0] = pre_a_r;
         OFS_PRE_B:          rdata[7:0] = pre_b_r;
         OFS_PRE_C:          rdata[7:0] = pre_c_r;
         OFS_CTRL:           rdata[7:0] = {4'h0, run_b_r, 1'b0, run_a_r, 1'b0};
         OFS_MODE_C:         rdata[7:0] = {eoc_c_r, 3'h0, outen_c_r, reload_c_r, run_c_r, 1'b0};
         OFS_STAT:           rdata[2:0] = stat_r;
         OFS_CLR:            rdata      = 32'h0000_0000;  // write only
         OFS_EN:             rdata[2:0] = en_r;
         default:            hit        = 1'b0;
      endcase
   end

   // write strobes for load and enable
   assign ld_a   = wr & (paddr == OFS_CTRL) & pwdata[CT_A_LD];
   assign ld_b   = wr & (paddr == OFS_CTRL) & pwdata[CT_B_LD];
   assign ld_c   = wr & (paddr == OFS_MODE_C) & pwdata[MD_LD];
   assign en_a_w = wr & (paddr == OFS_CTRL);
   assign en_b_w = en_a_w;
   assign en_c_w = wr & (paddr == OFS_MODE_C);

   // -----------------------------------------------
   // reload and prescale registers
   // -----------------------------------------------
   // reset puts a, b at 8-bit
   // reset puts c at 32-bit, output off
   always_ff @(posedge mclk) begin
      if (rst) begin
         ra_lo_r <= BYTE_RST;
         ra_hi_r <= BYTE_RST;
         rb_lo_r <= BYTE_RST;
         rb_hi_r <= BYTE_RST;
         rc_lo_r <= BYTE_RST;
         rc_hi_r <= BYTE_RST;
         pre_a_r <= PRE_RST;
         pre_b_r <= PRE_RST;
         pre_c_r <= PRE_RST;
         en_r    <= IRQ_RST;
      end else if (wr) begin
         case (paddr)
            OFS_A_LO:           ra_lo_r <= pwdata[7:0];
            OFS_B_LO:           rb_lo_r <= pwdata[7:0];
            OFS_C_LO:           rc_lo_r <= pwdata[7:0];
            OFS_A_LO | BANK_HI: ra_hi_r <= pwdata[7:0];
            OFS_B_LO | BANK_HI: rb_hi_r <= pwdata[7:0];
            OFS_C_LO | BANK_HI: rc_hi_r <= pwdata[7:0];
            OFS_PRE_A:          pre_a_r <= pwdata[7:0];
            OFS_PRE_B:          pre_b_r <= pwdata[7:0];
            OFS_PRE_C:          pre_c_r <= pwdata[7:0];
            OFS_EN:             en_r    <= pwdata[2:0];
            default:            ;
         endcase
      end
   end

   // -----------------------------------------------
   // clock sources and prescalers
   // -----------------------------------------------
   // internal clock is mclk / 2; external pin synced then edge-detected
   always_ff @(posedge mclk) begin
      if (rst) begin
         half_r     <= 1'b0;
         ext_sync_r <= 3'h0;
         p32_sync_r <= 2'h0;
      end else begin
         half_r     <= ~half_r;
         ext_sync_r <= {ext_sync_r[1:0], port3_bit1};
         p32_sync_r <= {p32_sync_r[0], port3_bit2};
      end
   end

   assign src_b = pre_b_r[PRE_EXT] ? (ext_sync_r[1] & ~ext_sync_r[2]) : half_r;

   cdt_prescaler u_pre_a (
      .mclk     (mclk),
      .rst      (rst),
      .restart  (ld_a),
      .src_tick (half_r),
      .div      (pre_a_r[7:PRE_DIV_L]),
      .tick     (tick_a)
   );
   cdt_prescaler u_pre_b (
      .mclk     (mclk),
      .rst      (rst),
      .restart  (ld_b),
      .src_tick (src_b),
      .div      (pre_b_r[7:PRE_DIV_L]),
      .tick     (tick_b)
   );
   cdt_prescaler u_pre_c (
      .mclk     (mclk),
      .rst      (rst),
      .restart  (ld_c),
      .src_tick (half_r),
      .div      (pre_c_r[7:PRE_DIV_L]),
      .tick     (tick_c)
   );

   // -----------------------------------------------
   // cascade assembly
   // -----------------------------------------------
   // sel: 0 = timer_a, 1 = timer_b, 2 = timer_c
   function automatic logic [31:0] pick(input logic [1:0] cm, input logic [1:0] sel,
                                        input logic [7:0] alo, input logic [7:0] ahi,
                                        input logic [7:0] blo, input logic [7:0] bhi,
                                        input logic [7:0] clo, input logic [7:0] chi);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (sel)
         2'h0: v = (cm == CASC_A16) ? {16'h0000, ahi, alo} : {24'h00_0000, alo};
         // timer_b 8, 16 or 24 bits
         2'h1: begin
            case (cm)
               CASC_C32: v = {24'h00_0000, blo};
               CASC_B24: v = {8'h00, ahi, bhi, blo};
               default:  v = {16'h0000, bhi, blo};
            endcase
         end
         // timer_c 16, 24 or 32 bits
         default: begin
            case (cm)
               CASC_C32: v = {ahi, bhi, chi, clo};
               CASC_C24: v = {8'h00, ahi, chi, clo};
               default:  v = {16'h0000, chi, clo};
            endcase
         end
      endcase
      return v;
   endfunction : pick

   // whole value decrements, end at terminal
   always_comb begin
      cur_a = pick(casc, 2'h0, a_lo_r, a_hi_r, b_lo_r, b_hi_r, c_lo_r, c_hi_r);
      cur_b = pick(casc, 2'h1, a_lo_r, a_hi_r, b_lo_r, b_hi_r, c_lo_r, c_hi_r);
      cur_c = pick(casc, 2'h2, a_lo_r, a_hi_r, b_lo_r, b_hi_r, c_lo_r, c_hi_r);
      rel_a = pick(casc, 2'h0, ra_lo_r, ra_hi_r, rb_lo_r, rb_hi_r, rc_lo_r, rc_hi_r);
      rel_b = pick(casc, 2'h1, ra_lo_r, ra_hi_r, rb_lo_r, rb_hi_r, rc_lo_r, rc_hi_r);
      rel_c = pick(casc, 2'h2, ra_lo_r, ra_hi_r, rb_lo_r, rb_hi_r, rc_lo_r, rc_hi_r);
      msk_a = pick(casc, 2'h0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
      msk_b = pick(casc, 2'h1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
      msk_c = pick(casc, 2'h2, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
      // end of count at one; zero loaded gives the full range
      term_a = run_a_r & tick_a & (cur_a == 32'h0000_0001);
      term_b = run_b_r & tick_b & (cur_b == 32'h0000_0001);
      term_c = run_c_r & tick_c & (cur_c == 32'h0000_0001);
   end

   always_comb begin
      nxt_a = cur_a;
      nxt_b = cur_b;
      nxt_c = cur_c;
      if (ld_a || (term_a && pre_a_r[PRE_MOD])) nxt_a = rel_a;
      else if (term_a)                          nxt_a = 32'h0000_0000;
      else if (run_a_r && tick_a)               nxt_a = (cur_a - 32'h0000_0001) & msk_a;
      if (ld_b || (term_b && pre_b_r[PRE_MOD])) nxt_b = rel_b;
      else if (term_b)                          nxt_b = 32'h0000_0000;
      else if (run_b_r && tick_b)               nxt_b = (cur_b - 32'h0000_0001) & msk_b;
      if (ld_c || (term_c && reload_c_r))       nxt_c = rel_c;
      else if (term_c)                          nxt_c = 32'h0000_0000;
      else if (run_c_r && tick_c)               nxt_c = (cur_c - 32'h0000_0001) & msk_c;
   end

   // -----------------------------------------------
   // counter bytes, high bytes go to their owner
   // -----------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         a_lo_r <= BYTE_RST;
         a_hi_r <= BYTE_RST;
         b_lo_r <= BYTE_RST;
         b_hi_r <= BYTE_RST;
         c_lo_r <= BYTE_RST;
         c_hi_r <= BYTE_RST;
      end else begin
         a_lo_r <= nxt_a[7:0];
         b_lo_r <= nxt_b[7:0];
         c_lo_r <= nxt_c[7:0];
         c_hi_r <= nxt_c[15:8];
         case (casc)
            CASC_C32: begin
               a_hi_r <= nxt_c[31:24];
               b_hi_r <= nxt_c[23:16];
            end
            CASC_C24: begin
               a_hi_r <= nxt_c[23:16];
               b_hi_r <= nxt_b[15:8];
            end
            CASC_A16: begin
               a_hi_r <= nxt_a[15:8];
               b_hi_r <= nxt_b[15:8];
            end
            default: begin
               a_hi_r <= nxt_b[23:16];
               b_hi_r <= nxt_b[15:8];
            end
         endcase
      end
   end

   // -----------------------------------------------
   // run control, single pass stops at end
   // -----------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         run_a_r <= 1'b0;
         run_b_r <= 1'b0;
      end else begin
         if (en_a_w)                          run_a_r <= pwdata[CT_A_EN];
         else if (term_a && !pre_a_r[PRE_MOD]) run_a_r <= 1'b0;
         if (en_b_w)                          run_b_r <= pwdata[CT_B_EN];
         else if (term_b && !pre_b_r[PRE_MOD]) run_b_r <= 1'b0;
      end
   end

   // timer_c mode register; the end flag set beats a clearing write
   always_ff @(posedge mclk) begin
      if (rst) begin
         run_c_r    <= MODE_RST[MD_EN];
         reload_c_r <= MODE_RST[MD_RELOAD];
         outen_c_r  <= MODE_RST[MD_OUTEN];
         eoc_c_r    <= MODE_RST[MD_EOC];
      end else begin
         if (en_c_w) begin
            reload_c_r <= pwdata[MD_RELOAD];
            outen_c_r  <= pwdata[MD_OUTEN];
         end
         if (en_c_w)                  run_c_r <= pwdata[MD_EN];
         else if (term_c && !reload_c_r) run_c_r <= 1'b0;
         // set by hardware, cleared by software
         if (term_c)      eoc_c_r <= 1'b1;
         else if (en_c_w) eoc_c_r <= eoc_c_r & pwdata[MD_EOC];
      end
   end

   // -----------------------------------------------
   // outputs to pins and interrupt lines
   // -----------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         port3_bit5   <= 1'b0;
         timer_a_irq  <= 1'b0;
         timer_b_irq  <= 1'b0;
         ext_irq_zero <= 1'b0;
         uart_bit_clk <= 1'b0;
      end else begin
         if (!outen_c_r)  port3_bit5 <= 1'b0;
         else if (term_c) port3_bit5 <= ~port3_bit5;
         timer_a_irq  <= term_a;
         timer_b_irq  <= term_b;
         ext_irq_zero <= (term_c & outen_c_r) | p32_sync_r[1];
         if (term_a) uart_bit_clk <= ~uart_bit_clk;
      end
   end

   // sticky status: set wins over clear in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         stat_r <= IRQ_RST;
         irq    <= 1'b0;
      end else begin
         stat_r <= (stat_r & ~((wr && paddr == OFS_CLR) ? pwdata[2:0] : 3'h0))
                   | {term_c & outen_c_r, term_b, term_a};
         irq    <= |(stat_r & en_r);
      end
   end
endmodule : cdt_top
`default_nettype wire
